// File: src/msal_pkg.sv
// package for the monitor status and alert logic: register offsets, field positions, resets
// assumes an 8-bit register port inside the device, driven by the serial bus engine
package msal_pkg;
   localparam logic [7:0] PRIMARY_FLAGS_ADDR   = 8'h41;
   localparam logic [7:0] SECONDARY_FLAGS_ADDR = 8'h42;
   localparam logic [7:0] PRIMARY_MASK_ADDR    = 8'h74;
   localparam logic [7:0] SECONDARY_MASK_ADDR  = 8'h75;
   localparam logic [7:0] CONFIG_A_ADDR        = 8'h78;
   localparam logic [7:0] CONFIG_B_ADDR        = 8'h7d;

   localparam logic [7:0] MASK_RESET     = 8'h00;
   localparam logic [7:0] CONFIG_A_RESET = 8'h00;
   localparam logic [7:0] CONFIG_B_RESET = 8'h00;

   localparam int SUMMARY_BIT      = 7;
   localparam int FAN_FOUR_BIT     = 5;
   localparam int ALERT_ENABLE_BIT = 0;
   localparam int THERMAL_EN_BIT   = 1;
   localparam int BOOST_BIT        = 2;
   localparam int THERMAL_SEL_BIT  = 1;

   localparam int ID_CODE_WIDTH = 6;
   localparam logic [7:0] DUTY_OFF = 8'h00;
endpackage

// File: src/msal_limit_check.sv
// one limit comparator: high limit strictly above, low limit at or below
// assumes measurement and limits are in the same code and on clk
module msal_limit_check #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] measurement,
   input  wire logic [WIDTH-1:0] lowLimit,
   input  wire logic [WIDTH-1:0] highLimit,
   output logic                  outOfLimit
);
   assign outOfLimit = (measurement > highLimit) || (measurement <= lowLimit);
endmodule

// File: src/msal_sticky_flags.sv
// eight sticky flags, set by a condition, cleared by a read only once the condition has gone
// assumes readStrobe is a one-cycle pulse on clk
module msal_sticky_flags (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] condition,
   input  wire logic       readStrobe,
   output logic [7:0]      flags
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags <= 8'h00;
      end else begin
         // a live condition keeps its bit through the read: set wins
         flags <= condition | (flags & ~{8{readStrobe}});
      end
   end
endmodule

// File: src/msal_alert_logic.sv
// status, mask and pin-function registers with the alert and fan-boost logic
// assumes limit comparisons arrive as levels on clk; pins are synchronised here
module msal_alert_logic
   import msal_pkg::*;
#(
   parameter int FANS = 4
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [7:0]               regAddr,
   input  wire logic                     regWrite,
   input  wire logic                     regRead,
   input  wire logic [7:0]               regWriteData,
   output logic      [7:0]               regReadData,
   input  wire logic [7:0]               twoFiveMeas,
   input  wire logic [7:0]               twoFiveLow,
   input  wire logic [7:0]               twoFiveHigh,
   input  wire logic [7:0]               coreVoltMeas,
   input  wire logic [7:0]               coreVoltLow,
   input  wire logic [7:0]               coreVoltHigh,
   input  wire logic [7:0]               supplyMeas,
   input  wire logic [7:0]               supplyLow,
   input  wire logic [7:0]               supplyHigh,
   input  wire logic [7:0]               fiveVoltMeas,
   input  wire logic [7:0]               fiveVoltLow,
   input  wire logic [7:0]               fiveVoltHigh,
   input  wire logic [7:0]               twelveVoltMeas,
   input  wire logic [7:0]               twelveVoltLow,
   input  wire logic [7:0]               twelveVoltHigh,
   input  wire logic [7:0]               remoteOneTempMeas,
   input  wire logic [7:0]               remoteOneTempLow,
   input  wire logic [7:0]               remoteOneTempHigh,
   input  wire logic [7:0]               localTempMeas,
   input  wire logic [7:0]               localTempLow,
   input  wire logic [7:0]               localTempHigh,
   input  wire logic [7:0]               remoteTwoTempMeas,
   input  wire logic [7:0]               remoteTwoTempLow,
   input  wire logic [7:0]               remoteTwoTempHigh,
   input  wire logic                     diodeOneFault,
   input  wire logic                     diodeTwoFault,
   input  wire logic [FANS-1:0]          fanSlow,
   input  wire logic                     overtemperatureFlag,
   input  wire logic                     thermalLimitExceeded,
   input  wire logic                     idChangeSelect,
   input  wire logic [ID_CODE_WIDTH-1:0] processorIdCode,
   input  wire logic                     fanFourSpeedPinIn,
   input  wire logic                     altThermalPinIn,
   input  wire logic [FANS-1:0]          fanRunning,
   output logic                          alertPinA_n,
   output logic                          alertPinAOe,
   output logic                          alertPinB_n,
   output logic                          alertPinBOe,
   output logic                          fanFullSpeed,
   output logic                          thermalPinSel,
   output logic                          thermalPinActive
);
   import msal_pkg::*;

   logic [7:0] primaryMask_reg;
   logic [7:0] secondaryMask_reg;
   logic [7:0] configA_reg;
   logic [7:0] configB_reg;
   logic [7:0] primaryFlags;
   logic [7:0] secondaryFlags;
   logic [7:0] primaryCond;
   logic [7:0] secondaryCond;
   logic [7:0] oolMeas [8];
   logic [7:0] oolLow  [8];
   logic [7:0] oolHigh [8];
   logic [7:0] oolHit;
   logic [ID_CODE_WIDTH-1:0] idMeta_reg;
   logic [ID_CODE_WIDTH-1:0] idSync_reg;
   logic [ID_CODE_WIDTH-1:0] idPrev_reg;
   logic [2:0] idPrimed_reg;
   logic       idChanged;
   logic [1:0] fanFourSync_reg;
   logic [1:0] altThermSync_reg;
   logic       thermalLow;
   logic       primaryRead;
   logic       secondaryRead;
   logic       alertActive;
   logic [7:0] readNext;
   logic       primaryMaskWrite;
   logic       secondaryMaskWrite;
   logic       configAWrite;
   logic       configBWrite;
   logic       fanFourIsThermal;
   logic       fanFourPinLow;
   logic       altPinLow;
   logic       anyFanRunning;
   logic [6:0] primaryAlertHits;
   logic [7:0] secondaryAlertHits;
   logic       secondaryAlertAny;
   logic       alertEnableA;
   logic       alertEnableB;

   // channel order matches primary bits 0..6, twelve volt last
   assign oolMeas[0] = twoFiveMeas;
   assign oolLow[0]  = twoFiveLow;
   assign oolHigh[0] = twoFiveHigh;
   assign oolMeas[1] = coreVoltMeas;
   assign oolLow[1]  = coreVoltLow;
   assign oolHigh[1] = coreVoltHigh;
   assign oolMeas[2] = supplyMeas;
   assign oolLow[2]  = supplyLow;
   assign oolHigh[2] = supplyHigh;
   assign oolMeas[3] = fiveVoltMeas;
   assign oolLow[3]  = fiveVoltLow;
   assign oolHigh[3] = fiveVoltHigh;
   assign oolMeas[4] = remoteOneTempMeas;
   assign oolLow[4]  = remoteOneTempLow;
   assign oolHigh[4] = remoteOneTempHigh;
   assign oolMeas[5] = localTempMeas;
   assign oolLow[5]  = localTempLow;
   assign oolHigh[5] = localTempHigh;
   assign oolMeas[6] = remoteTwoTempMeas;
   assign oolLow[6]  = remoteTwoTempLow;
   assign oolHigh[6] = remoteTwoTempHigh;
   assign oolMeas[7] = twelveVoltMeas;
   assign oolLow[7]  = twelveVoltLow;
   assign oolHigh[7] = twelveVoltHigh;

   genvar ch;
   generate
      for (ch = 0; ch < 8; ch++) begin : g_limit
         msal_limit_check #(
            .WIDTH(8)
         ) u_check (
            .measurement(oolMeas[ch]),
            .lowLimit   (oolLow[ch]),
            .highLimit  (oolHigh[ch]),
            .outOfLimit (oolHit[ch])
         );
      end
   endgenerate

   // id code pins come from outside: two flops before compare
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idMeta_reg <= '0;
         idSync_reg <= '0;
         idPrev_reg <= '0;
      end else begin
         idMeta_reg <= processorIdCode;
         idSync_reg <= idMeta_reg;
         idPrev_reg <= idSync_reg;
      end
   end

   // one bit per pipe stage: all set once real pin values have filled it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         idPrimed_reg <= 3'b000;
      end else begin
         idPrimed_reg <= {idPrimed_reg[1:0], 1'b1};
      end
   end
   // a nonzero code at reset release would otherwise read as a change
   assign idChanged = idPrimed_reg[2] && (idSync_reg != idPrev_reg);

   // thermal pins idle high, so the sync stages reset high too
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fanFourSync_reg <= 2'b11;
      end else begin
         fanFourSync_reg <= {fanFourSync_reg[0], fanFourSpeedPinIn};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         altThermSync_reg <= 2'b11;
      end else begin
         altThermSync_reg <= {altThermSync_reg[0], altThermalPinIn};
      end
   end

   assign thermalPinActive = configA_reg[THERMAL_EN_BIT];
   assign thermalPinSel    = configB_reg[THERMAL_SEL_BIT];
   // low level on a pin is an outside thermal assertion
   assign fanFourPinLow    = !fanFourSync_reg[1];
   assign altPinLow        = !altThermSync_reg[1];
   // only the selected pin is read, never both
   assign thermalLow       = thermalPinActive &&
                             (thermalPinSel ? altPinLow : fanFourPinLow);
   // fan four pin doubles as the thermal input when chosen
   assign fanFourIsThermal = thermalPinActive && !thermalPinSel;

   always_comb begin
      primaryCond = {1'b0, oolHit[6:0]};
      secondaryCond = 8'h00;
      secondaryCond[7] = diodeTwoFault;
      secondaryCond[6] = diodeOneFault;
      // thermal use of the fan four pin swaps the source of bit 5
      secondaryCond[FAN_FOUR_BIT] = fanFourIsThermal ? thermalLimitExceeded : fanSlow[3];
      secondaryCond[4:2] = fanSlow[2:0];
      secondaryCond[1] = overtemperatureFlag;
      secondaryCond[0] = idChangeSelect ? idChanged : oolHit[7];
   end

   assign primaryRead   = regRead && (regAddr == PRIMARY_FLAGS_ADDR);
   assign secondaryRead = regRead && (regAddr == SECONDARY_FLAGS_ADDR);

   msal_sticky_flags u_primary (
      .clk       (clk),
      .rst_n     (rst_n),
      .condition (primaryCond),
      .readStrobe(primaryRead),
      .flags     (primaryFlags)
   );

   msal_sticky_flags u_secondary (
      .clk       (clk),
      .rst_n     (rst_n),
      .condition (secondaryCond),
      .readStrobe(secondaryRead),
      .flags     (secondaryFlags)
   );

   // status registers have no write decode, so writes to them are dropped
   assign primaryMaskWrite   = regWrite && (regAddr == PRIMARY_MASK_ADDR);
   assign secondaryMaskWrite = regWrite && (regAddr == SECONDARY_MASK_ADDR);
   assign configAWrite       = regWrite && (regAddr == CONFIG_A_ADDR);
   assign configBWrite       = regWrite && (regAddr == CONFIG_B_ADDR);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         primaryMask_reg <= MASK_RESET;
      end else if (primaryMaskWrite) begin
         primaryMask_reg <= regWriteData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         secondaryMask_reg <= MASK_RESET;
      end else if (secondaryMaskWrite) begin
         secondaryMask_reg <= regWriteData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         configA_reg <= CONFIG_A_RESET;
      end else if (configAWrite) begin
         configA_reg <= regWriteData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         configB_reg <= CONFIG_B_RESET;
      end else if (configBWrite) begin
         configB_reg <= regWriteData;
      end
   end

   // summary is live from the secondary flags, so it clears with them
   always_comb begin
      case (regAddr)
         PRIMARY_FLAGS_ADDR:   readNext = {|secondaryFlags, primaryFlags[6:0]};
         SECONDARY_FLAGS_ADDR: readNext = secondaryFlags;
         PRIMARY_MASK_ADDR:    readNext = primaryMask_reg;
         SECONDARY_MASK_ADDR:  readNext = secondaryMask_reg;
         CONFIG_A_ADDR:        readNext = configA_reg;
         CONFIG_B_ADDR:        readNext = configB_reg;
         default:              readNext = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regReadData <= 8'h00;
      end else if (regRead) begin
         regReadData <= readNext;
      end
   end

   // flags latch regardless of masks; masks act only here
   assign primaryAlertHits   = primaryFlags[6:0] & ~primaryMask_reg[6:0];
   assign secondaryAlertHits = secondaryFlags & ~secondaryMask_reg;
   // one mask bit holds back the whole secondary register
   assign secondaryAlertAny  = !primaryMask_reg[SUMMARY_BIT] && (|secondaryAlertHits);
   // flags are sticky, so this stays up after the cause until the read
   assign alertActive        = (|primaryAlertHits) || secondaryAlertAny;
   assign alertEnableA       = configA_reg[ALERT_ENABLE_BIT];
   assign alertEnableB       = configB_reg[ALERT_ENABLE_BIT];

   // open drain: drive low only while active and enabled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alertPinA_n <= 1'b1;
         alertPinAOe <= 1'b0;
      end else begin
         alertPinAOe <= alertEnableA && alertActive;
         alertPinA_n <= !(alertEnableA && alertActive);
      end
   end

   // both pins may be enabled at once; each follows its own enable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alertPinB_n <= 1'b1;
         alertPinBOe <= 1'b0;
      end else begin
         alertPinBOe <= alertEnableB && alertActive;
         alertPinB_n <= !(alertEnableB && alertActive);
      end
   end

   // boost ignores per-fan duty: any running fan lets it act
   assign anyFanRunning = |fanRunning;

   // boost needs at least one running fan: with all fans idle, fanFullSpeed stays low
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fanFullSpeed <= 1'b0;
      end else begin
         fanFullSpeed <= configA_reg[BOOST_BIT] && thermalLow && anyFanRunning;
      end
   end
endmodule

// File: verification/msal_alert_logic_properties.sv
// checker for the status and alert block, sees only its ports
// assumes one clock domain and a synchronous active-low reset
module msal_alert_checker #(
   parameter int FANS = 4
) (
   input wire logic            clk,
   input wire logic            rst_n,
   input wire logic [7:0]      regAddr,
   input wire logic            regWrite,
   input wire logic [7:0]      regWriteData,
   input wire logic [FANS-1:0] fanRunning,
   input wire logic            alertPinA_n,
   input wire logic            alertPinAOe,
   input wire logic            alertPinB_n,
   input wire logic            alertPinBOe,
   input wire logic            fanFullSpeed,
   input wire logic            thermalPinSel,
   input wire logic            thermalPinActive
);
   timeunit 1ns;
   timeprecision 1ps;
   import msal_pkg::*;
   logic [7:0] cfgA_reg;
   logic [7:0] cfgB_reg;
   // shadow copies, so enables can be tied to the writes that set them
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfgA_reg <= CONFIG_A_RESET;
         cfgB_reg <= CONFIG_B_RESET;
      end else if (regWrite && regAddr == CONFIG_A_ADDR) begin
         cfgA_reg <= regWriteData;
      end else if (regWrite && regAddr == CONFIG_B_ADDR) begin
         cfgB_reg <= regWriteData;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_alert_off: assert property ($rose(rst_n) |-> !alertPinAOe && alertPinA_n
      && !alertPinBOe && alertPinB_n && !fanFullSpeed) else $error("outputs not idle at reset");
   a_pin_a_pair: assert property (alertPinAOe != alertPinA_n)
      else $error("pin a drive and level disagree");
   a_pin_b_pair: assert property (alertPinBOe != alertPinB_n)
      else $error("pin b drive and level disagree");
   a_enable_a_gate: assert property (alertPinAOe |-> $past(cfgA_reg[ALERT_ENABLE_BIT]))
      else $error("pin a driven while disabled");
   a_enable_b_gate: assert property (alertPinBOe |-> $past(cfgB_reg[ALERT_ENABLE_BIT]))
      else $error("pin b driven while disabled");
   a_boost_needs_run: assert property (fanFullSpeed |-> |$past(fanRunning))
      else $error("boost with no fan running");
   a_boost_needs_cfg: assert property (fanFullSpeed |-> $past(cfgA_reg[BOOST_BIT]))
      else $error("boost while boost bit clear");
   a_pin_select_map: assert property (thermalPinSel == cfgB_reg[THERMAL_SEL_BIT])
      else $error("pin select differs from config");
   a_thermal_en_map: assert property (thermalPinActive == cfgA_reg[THERMAL_EN_BIT])
      else $error("thermal enable differs from config");
endmodule

bind msal_alert_logic msal_alert_checker #(.FANS(FANS)) i_checker (
   .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
   .regWriteData(regWriteData), .fanRunning(fanRunning), .alertPinA_n(alertPinA_n),
   .alertPinAOe(alertPinAOe), .alertPinB_n(alertPinB_n), .alertPinBOe(alertPinBOe),
   .fanFullSpeed(fanFullSpeed), .thermalPinSel(thermalPinSel),
   .thermalPinActive(thermalPinActive));

// File: verification/msal_host_model.sv
// host side of the register port: single-cycle read and write strobes
// assumes requests launch on the falling clock edge
module msal_host_model (
   input  wire logic [7:0] regReadData,
   input  wire logic       clk,
   output logic      [7:0] regAddr,
   output logic            regWrite,
   output logic            regRead,
   output logic      [7:0] regWriteData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      regAddr = 8'h00;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWriteData = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      regWriteData = ~d;   // stale data must not look valid
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      d = regReadData;
   endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the status and alert block
// assumes the host model drives the register port
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import msal_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] meas[8], lo[8], hi[8];
   logic [7:1] src;
   logic       thLim, idSel, pin4, pinAlt, wrS, rdS, aN, aOe, bN, bOe, full, sel, act;
   logic [5:0] idCode;
   logic [3:0] fanRun;
   logic [7:0] addr, wdat, rdat, got, a, b;
   logic [7:0] resetList[7] = '{PRIMARY_FLAGS_ADDR, SECONDARY_FLAGS_ADDR, PRIMARY_MASK_ADDR,
      SECONDARY_MASK_ADDR, CONFIG_A_ADDR, CONFIG_B_ADDR, 8'h40};
   int         n_fail = 0, checked = 0, cyc = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   msal_alert_logic i_dut (.clk(clk), .rst_n(rst_n), .regAddr(addr), .regWrite(wrS),
      .regRead(rdS), .regWriteData(wdat), .regReadData(rdat),
      .twoFiveMeas(meas[0]), .twoFiveLow(lo[0]), .twoFiveHigh(hi[0]),
      .coreVoltMeas(meas[1]), .coreVoltLow(lo[1]), .coreVoltHigh(hi[1]),
      .supplyMeas(meas[2]), .supplyLow(lo[2]), .supplyHigh(hi[2]),
      .fiveVoltMeas(meas[3]), .fiveVoltLow(lo[3]), .fiveVoltHigh(hi[3]),
      .remoteOneTempMeas(meas[4]), .remoteOneTempLow(lo[4]), .remoteOneTempHigh(hi[4]),
      .localTempMeas(meas[5]), .localTempLow(lo[5]), .localTempHigh(hi[5]),
      .remoteTwoTempMeas(meas[6]), .remoteTwoTempLow(lo[6]), .remoteTwoTempHigh(hi[6]),
      .twelveVoltMeas(meas[7]), .twelveVoltLow(lo[7]), .twelveVoltHigh(hi[7]),
      .diodeOneFault(src[6]), .diodeTwoFault(src[7]), .fanSlow(src[5:2]),
      .overtemperatureFlag(src[1]), .thermalLimitExceeded(thLim), .idChangeSelect(idSel),
      .processorIdCode(idCode), .fanFourSpeedPinIn(pin4), .altThermalPinIn(pinAlt),
      .fanRunning(fanRun), .alertPinA_n(aN), .alertPinAOe(aOe), .alertPinB_n(bN),
      .alertPinBOe(bOe), .fanFullSpeed(full), .thermalPinSel(sel), .thermalPinActive(act));
   msal_host_model i_host (.clk(clk), .regReadData(rdat), .regAddr(addr), .regWrite(wrS),
      .regRead(rdS), .regWriteData(wdat));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
      i_host.rd(ra, got);
      chk($sformatf("register %h", ra), exp, got);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pulse(input int k);
      src[k] = 1'b1;
      idle(3);
      src = '0;
   endtask
   task automatic alert_case(input logic [7:0] m1, m2, input int k, input logic fire);
      i_host.wr(PRIMARY_MASK_ADDR, m1);
      i_host.wr(SECONDARY_MASK_ADDR, m2);
      pulse(k);
      idle(3);
      chk("alert a", {7'h0, !fire}, {7'h0, aN});   // low after the cause is gone when fire is set, high when masked
      chk("alert b", 8'h01, {7'h0, bN});
      chk("alert a drive", {7'h0, fire}, {7'h0, aOe});
      chk("alert b drive", 8'h00, {7'h0, bOe});
      rchk(SECONDARY_FLAGS_ADDR, 8'h01 << k);
      idle(2);
      chk("alert a after read", 8'h01, {7'h0, aN});
   endtask
   task end_sim;
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 8; i++) begin
         meas[i] = 8'h80;
         lo[i] = 8'h10;
         hi[i] = 8'hf0;
      end
      src = '0;
      {thLim, idSel, pin4, pinAlt, fanRun, idCode} = {4'b0011, 4'h0, 6'h00};
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      foreach (resetList[j]) rchk(resetList[j], 8'h00);
      i_host.wr(SECONDARY_FLAGS_ADDR, 8'hff);
      rchk(SECONDARY_FLAGS_ADDR, 8'h00);
      i_host.wr(8'h40, 8'hff);
      rchk(8'h40, 8'h00);
      for (int i = 0; i < 8; i++) begin
         a = (i < 7) ? PRIMARY_FLAGS_ADDR : SECONDARY_FLAGS_ADDR;
         b = (i < 7) ? 8'h01 << i : 8'h01;
         meas[i] = hi[i];
         rchk(a, 8'h00);
         meas[i] = hi[i] + 8'h01;
         rchk(a, b);
         meas[i] = lo[i] + 8'h01;
         rchk(a, b);
         rchk(a, 8'h00);
         meas[i] = lo[i];
         rchk(a, b);
         meas[i] = 8'h80;
         rchk(a, b);
         rchk(a, 8'h00);
      end
      for (int k = 1; k < 8; k++) begin
         pulse(k);
         rchk(PRIMARY_FLAGS_ADDR, 8'h80);
         rchk(SECONDARY_FLAGS_ADDR, 8'h01 << k);
         rchk(PRIMARY_FLAGS_ADDR, 8'h00);
      end
      i_host.wr(CONFIG_A_ADDR, 8'h02);
      pulse(5);
      rchk(SECONDARY_FLAGS_ADDR, 8'h00);
      thLim = 1'b1;
      idle(3);
      thLim = 1'b0;
      rchk(SECONDARY_FLAGS_ADDR, 8'h20);
      idSel = 1'b1;
      idCode = 6'h2a;
      idle(6);
      rchk(SECONDARY_FLAGS_ADDR, 8'h01);
      rchk(SECONDARY_FLAGS_ADDR, 8'h00);
      i_host.wr(CONFIG_A_ADDR, 8'h01);
      alert_case(8'h00, 8'h00, 7, 1'b1);
      alert_case(8'h80, 8'h00, 6, 1'b0);
      alert_case(8'h00, 8'h40, 6, 1'b0);
      alert_case(8'h00, 8'h20, 5, 1'b0);
      alert_case(8'h00, 8'h00, 1, 1'b1);
      i_host.wr(PRIMARY_MASK_ADDR, 8'h08);
      meas[3] = 8'h00;
      idle(3);
      chk("alert masked", 8'h01, {7'h0, aN});
      meas[3] = 8'h80;
      rchk(PRIMARY_FLAGS_ADDR, 8'h08);
      meas[5] = 8'h00;
      idle(3);
      chk("alert live", 8'h00, {7'h0, aN});
      rchk(PRIMARY_FLAGS_ADDR, 8'h20);
      idle(2);
      chk("alert live after read", 8'h00, {7'h0, aN});
      i_host.wr(PRIMARY_MASK_ADDR, 8'h20);
      idle(2);
      chk("alert masked live", 8'h01, {7'h0, aN});
      meas[5] = 8'h80;
      rchk(PRIMARY_FLAGS_ADDR, 8'h20);
      rchk(PRIMARY_FLAGS_ADDR, 8'h00);
      i_host.wr(PRIMARY_MASK_ADDR, 8'h00);
      idle(2);
      chk("alert after unmask", 8'h01, {7'h0, aN});
      i_host.wr(CONFIG_A_ADDR, 8'h00);
      i_host.wr(CONFIG_B_ADDR, 8'h01);
      pulse(2);
      idle(2);
      chk("alert b", 8'h00, {7'h0, bN});
      chk("alert b drive", 8'h01, {7'h0, bOe});
      chk("alert a drive", 8'h00, {7'h0, aOe});
      chk("alert a", 8'h01, {7'h0, aN});
      rchk(SECONDARY_FLAGS_ADDR, 8'h04);
      i_host.wr(CONFIG_B_ADDR, 8'h00);
      i_host.wr(CONFIG_A_ADDR, 8'h06);
      chk("thermal enable", 8'h01, {7'h0, act});
      chk("thermal pin select", 8'h00, {7'h0, sel});
      pin4 = 1'b0;
      idle(5);
      chk("boost idle fans", 8'h00, {7'h0, full});
      pin4 = 1'b1;
      fanRun = 4'h2;
      idle(5);
      pin4 = 1'b0;
      idle(5);
      chk("boost", 8'h01, {7'h0, full});
      pin4 = 1'b1;
      idle(5);
      chk("boost end", 8'h00, {7'h0, full});
      i_host.wr(CONFIG_B_ADDR, 8'h02);
      chk("thermal pin alt", 8'h01, {7'h0, sel});
      pin4 = 1'b0;
      idle(5);
      chk("boost wrong pin", 8'h00, {7'h0, full});
      pin4 = 1'b1;
      pinAlt = 1'b0;
      idle(5);
      chk("boost alt pin", 8'h01, {7'h0, full});
      end_sim();
   end
endmodule
